//--- hw/isa_bus_pins.sv
// expansion bus write strobe, refresh, bus reset and address pin logic
`timescale 1ns/1ps
module isa_bus_pins #(
	parameter int HARD_RESET_CYCLES = isa_sig_pkg::HARD_RESET_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// reset sources
	input wire logic power_good_in,
	input wire logic hard_reset_req,
	// bus ownership and suspend
	input wire logic own_bus,
	input wire logic suspend,
	// cycle request from the bridge core
	input wire logic cyc_start,
	input wire isa_sig_pkg::cyc_kind_t cyc_kind,
	input wire logic [isa_sig_pkg::ADDR_W-1:0] cyc_addr,
	output logic cyc_busy,
	output logic cyc_done,
	// memory write strobe pin
	output logic mem_write_strobe_n_out,
	output logic mem_write_strobe_n_oe_n,
	input wire logic mem_write_strobe_n_in,
	// memory read strobe pin
	output logic mem_read_strobe_n_out,
	output logic mem_read_strobe_n_oe_n,
	// refresh indicator pin
	output logic refresh_n_out,
	output logic refresh_n_oe_n,
	input wire logic refresh_n_in,
	// address pins
	output logic [isa_sig_pkg::SA_W-1:0] sys_addr_out,
	output logic sys_addr_oe_n,
	input wire logic [isa_sig_pkg::SA_W-1:0] sys_addr_in,
	output logic [isa_sig_pkg::LA_W-1:0] upper_latched_addr_out,
	output logic upper_latched_addr_oe_n,
	// bus reset and external master observations
	output logic bus_reset_out,
	output logic [isa_sig_pkg::SA_W-1:0] ext_sys_addr,
	output logic ext_mem_write,
	output logic ext_refresh_start
);
	localparam logic [isa_sig_pkg::HR_W-1:0] HR_LOAD =
		isa_sig_pkg::HR_W'(HARD_RESET_CYCLES);
	localparam logic [isa_sig_pkg::STEP_W-1:0] SETUP_LAST =
		isa_sig_pkg::STEP_W'(isa_sig_pkg::SETUP_CYCLES - 1);
	localparam logic [isa_sig_pkg::STEP_W-1:0] STROBE_LAST =
		isa_sig_pkg::STEP_W'(isa_sig_pkg::STROBE_CYCLES - 1);
	isa_sig_pkg::state_t st_reg;
	isa_sig_pkg::state_t st_next;
	logic pg_sync;
	logic wr_sync_n;
	logic ref_sync_n;
	logic [isa_sig_pkg::SA_W-1:0] sa_sync;
	logic start_ok;

	bit_sync2 #(.W(3), .RESET_VAL(3'h6)) ctl_sync (
		.clk(clk),
		.rst(rst),
		.d({mem_write_strobe_n_in, refresh_n_in, power_good_in}),
		.q({wr_sync_n, ref_sync_n, pg_sync})
	);

	bit_sync2 #(.W(isa_sig_pkg::SA_W)) addr_sync (
		.clk(clk),
		.rst(rst),
		.d(sys_addr_in),
		.q(sa_sync)
	);

	assign start_ok = cyc_start && own_bus && !suspend &&
		!st_reg.bus_reset && st_reg.phase == isa_sig_pkg::PH_IDLE;

	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.ext_ref_start = 1'b0;
		// hard reset count restarts on every request
		if (hard_reset_req) begin
			st_next.hr_cnt = HR_LOAD;
		end else if (st_reg.hr_cnt != '0) begin
			st_next.hr_cnt = st_reg.hr_cnt - 1'b1;
		end
		st_next.bus_reset = !pg_sync || st_next.hr_cnt != '0;
		// pins follow ownership one edge later
		st_next.ctl_oe_n = !own_bus;
		st_next.addr_oe_n = !own_bus;
		case (st_reg.phase)
			isa_sig_pkg::PH_IDLE: begin
				if (start_ok) begin
					st_next.kind = cyc_kind;
					st_next.la = cyc_addr[isa_sig_pkg::ADDR_W-1:
						isa_sig_pkg::LA_LSB];
					if (cyc_kind == isa_sig_pkg::KIND_IO) begin
						// upper bits undefined for I/O; driven as zero
						st_next.sa = {4'h0,
							cyc_addr[isa_sig_pkg::IO_ADDR_W-1:0]};
					end else begin
						st_next.sa = cyc_addr[isa_sig_pkg::SA_W-1:0];
					end
					st_next.ref_n = cyc_kind != isa_sig_pkg::KIND_REFRESH;
					st_next.step = SETUP_LAST;
					st_next.busy = 1'b1;
					st_next.phase = isa_sig_pkg::PH_SETUP;
				end
			end
			isa_sig_pkg::PH_SETUP: begin
				if (st_reg.step != '0) begin
					st_next.step = st_reg.step - 1'b1;
				end else begin
					// dma and core writes share this strobe path
					st_next.wr_n =
						st_reg.kind != isa_sig_pkg::KIND_MEM_WRITE;
					st_next.rd_n = !(st_reg.kind == isa_sig_pkg::KIND_MEM_READ ||
						st_reg.kind == isa_sig_pkg::KIND_REFRESH);
					st_next.step = STROBE_LAST;
					st_next.phase = isa_sig_pkg::PH_STROBE;
				end
			end
			isa_sig_pkg::PH_STROBE: begin
				if (st_reg.step != '0) begin
					st_next.step = st_reg.step - 1'b1;
				end else begin
					st_next.wr_n = 1'b1;
					st_next.rd_n = 1'b1;
					st_next.ref_n = 1'b1;
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
					st_next.phase = isa_sig_pkg::PH_IDLE;
				end
			end
			default: begin
				st_next.phase = isa_sig_pkg::PH_IDLE;
			end
		endcase
		// losing the bus aborts a cycle so no strobe is left low
		if (!own_bus && st_reg.phase != isa_sig_pkg::PH_IDLE) begin
			st_next.wr_n = 1'b1;
			st_next.rd_n = 1'b1;
			st_next.ref_n = 1'b1;
			st_next.busy = 1'b0;
			st_next.done = 1'b1;
			st_next.phase = isa_sig_pkg::PH_IDLE;
		end
		// external master side: sample address and commands
		st_next.ref_prev = ref_sync_n;
		if (!st_reg.ctl_oe_n) begin
			st_next.ext_wr = 1'b0;
		end else begin
			st_next.ext_wr = !wr_sync_n;
			st_next.ext_ref_start = st_reg.ref_prev && !ref_sync_n;
		end
		if (st_reg.addr_oe_n) begin
			st_next.ext_sa = sa_sync;
		end
		if (rst) begin
			st_next = isa_sig_pkg::STATE_RESET;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign cyc_busy = st_reg.busy;
	assign cyc_done = st_reg.done;
	assign mem_write_strobe_n_out = st_reg.wr_n;
	assign mem_write_strobe_n_oe_n = st_reg.ctl_oe_n;
	assign mem_read_strobe_n_out = st_reg.rd_n;
	assign mem_read_strobe_n_oe_n = st_reg.ctl_oe_n;
	assign refresh_n_out = st_reg.ref_n;
	assign refresh_n_oe_n = st_reg.ctl_oe_n;
	assign sys_addr_out = st_reg.sa;
	assign sys_addr_oe_n = st_reg.addr_oe_n;
	assign upper_latched_addr_out = st_reg.la;
	assign upper_latched_addr_oe_n = st_reg.addr_oe_n;
	assign bus_reset_out = st_reg.bus_reset;
	assign ext_sys_addr = st_reg.ext_sa;
	assign ext_mem_write = st_reg.ext_wr;
	assign ext_refresh_start = st_reg.ext_ref_start;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence write_accept_s;
		start_ok && cyc_kind == isa_sig_pkg::KIND_MEM_WRITE;
	endsequence

	// strobe falls on the edge that closes the two setup cycles
	sequence strobe_seen_s;
		##1 !mem_write_strobe_n_out;
	endsequence

	strobe_write_only_a: assert property (
		!mem_write_strobe_n_out |->
		st_reg.kind == isa_sig_pkg::KIND_MEM_WRITE &&
		st_reg.phase == isa_sig_pkg::PH_STROBE)
		else $error("write strobe low outside a write strobe phase");

	strobe_release_a: assert property (
		!$past(own_bus) |-> mem_write_strobe_n_oe_n && mem_write_strobe_n_out)
		else $error("write strobe driven while another master owns bus");

	write_strobe_issue_a: assert property (
		write_accept_s ##1 own_bus [*2] |-> strobe_seen_s)
		else $error("accepted write never asserted the write strobe");

	ext_refresh_a: assert property (
		st_reg.ctl_oe_n && st_reg.ref_prev && !ref_sync_n |=>
		ext_refresh_start)
		else $error("external refresh start not reported");

	reset_pg_a: assert property (
		!pg_sync |=> bus_reset_out)
		else $error("bus reset released while power good inactive");

	hard_reset_hold_a: assert property (
		hard_reset_req |=> bus_reset_out && st_reg.hr_cnt == HR_LOAD)
		else $error("hard reset did not load the hold count");

	hard_count_a: assert property (
		st_reg.hr_cnt != '0 |-> bus_reset_out)
		else $error("bus reset low while hard reset count runs");

	addr_overlap_a: assert property (
		st_reg.busy && st_reg.kind != isa_sig_pkg::KIND_IO |->
		sys_addr_out[isa_sig_pkg::SA_W-1:isa_sig_pkg::LA_LSB] ==
		upper_latched_addr_out[2:0])
		else $error("overlapping address bits differ from latched bits");

	io_addr_a: assert property (
		write_accept_s or (start_ok && cyc_kind == isa_sig_pkg::KIND_IO) |=>
		sys_addr_out[isa_sig_pkg::IO_ADDR_W-1:0] ==
		$past(cyc_addr[isa_sig_pkg::IO_ADDR_W-1:0]))
		else $error("low address bits not taken from the request");

	addr_own_a: assert property (
		$past(own_bus) && !$past(rst) |-> !sys_addr_oe_n)
		else $error("address not driven while owning bus");

	cycle_len_a: assert property (
		start_ok ##1 own_bus [*5] |->
		$past(cyc_busy, 4) && cyc_busy ##1 !cyc_busy)
		else $error("bus cycle length wrong");

	reset_float_a: assert property (
		@(posedge clk) disable iff (1'b0) rst |=>
		mem_write_strobe_n_oe_n && refresh_n_oe_n && sys_addr_oe_n &&
		bus_reset_out)
		else $error("pins not floated or bus reset low during reset");
endmodule // isa_bus_pins

//--- common/isa_sig_pkg.sv
// constants and types for the expansion bus pin logic
package isa_sig_pkg;

	localparam int SA_W = 20;
	localparam int LA_W = 7;
	localparam int LA_LSB = 17;
	localparam int ADDR_W = 24;
	localparam int IO_ADDR_W = 16;
	localparam int HR_W = 20;
	localparam int STEP_W = 8;

	localparam int CLK_PERIOD_PS = 4000;
	localparam longint HARD_RESET_MIN_NS = 1000000;
	// a least time rounds up to whole cycles
	localparam int HARD_RESET_CYCLES_DEF =
		int'((HARD_RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int SETUP_CYCLES = 2;
	localparam int STROBE_CYCLES = 3;

	typedef enum logic [1:0] {
		KIND_MEM_WRITE,
		KIND_MEM_READ,
		KIND_IO,
		KIND_REFRESH
	} cyc_kind_t;

	typedef enum logic [1:0] {
		PH_IDLE,
		PH_SETUP,
		PH_STROBE
	} phase_t;

	typedef struct packed {
		phase_t phase;
		cyc_kind_t kind;
		logic [STEP_W-1:0] step;
		logic [HR_W-1:0] hr_cnt;
		logic bus_reset;
		logic busy;
		logic done;
		logic wr_n;
		logic rd_n;
		logic ref_n;
		logic ctl_oe_n;
		logic addr_oe_n;
		logic [SA_W-1:0] sa;
		logic [LA_W-1:0] la;
		logic [SA_W-1:0] ext_sa;
		logic ext_wr;
		logic ref_prev;
		logic ext_ref_start;
	} state_t;

	localparam state_t STATE_RESET = '{
		phase: PH_IDLE,
		kind: KIND_MEM_WRITE,
		step: '0,
		hr_cnt: '0,
		bus_reset: 1'b1,
		busy: 1'b0,
		done: 1'b0,
		wr_n: 1'b1,
		rd_n: 1'b1,
		ref_n: 1'b1,
		ctl_oe_n: 1'b1,
		addr_oe_n: 1'b1,
		sa: '0,
		la: '0,
		ext_sa: '0,
		ext_wr: 1'b0,
		ref_prev: 1'b1,
		ext_ref_start: 1'b0
	};

endpackage

//--- hw/bit_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bit_sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// asynchronous in, synchronised out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// a wide bus is not sampled coherently; callers read it only when stable
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // bit_sync2

//--- dv/isa_far_side.sv
// far side model: memory slave and external bus master on the pins
`timescale 1ns/1ps
module isa_far_side (
	// clock
	input wire logic clk,
	// device pin drivers
	input wire logic wr_o,
	input wire logic wr_oe,
	input wire logic ref_o,
	input wire logic ref_oe,
	input wire logic [19:0] sa_o,
	input wire logic sa_oe,
	// external master controls from the bench
	input wire logic m_en,
	input wire logic m_wr,
	input wire logic m_ref,
	input wire logic [19:0] m_sa,
	// resolved pin levels
	output logic wr_i,
	output logic ref_i,
	output logic [19:0] sa_i,
	// slave observation
	output int latch_cnt
);
	logic [19:0] sa_last = '0;
	initial latch_cnt = 0;
	// command lines have pull-ups, so a released strobe reads high
	assign wr_i = !wr_oe ? wr_o : (m_en ? m_wr : 1'b1);
	assign ref_i = !ref_oe ? ref_o : (m_en ? m_ref : 1'b1);
	// a floating address shows the inverse of its last value
	assign sa_i = !sa_oe ? sa_o : (m_en ? m_sa : ~sa_last);
	// this slave never drives data, refresh included
	always @(posedge clk) begin
		if (!wr_i)
			latch_cnt <= latch_cnt + 1;
		if (!sa_oe || m_en)
			sa_last <= sa_i;
	end
endmodule // isa_far_side

//--- dv/tb_isa_bus_pins.sv
// self-checking bench for the expansion bus pin logic
`timescale 1ns/1ps
module tb_isa_bus_pins;
	localparam int HR = 20;
	logic clk = 0, rst = 1, pg = 0, hr_req = 0, own = 1, susp = 0, start = 0;
	isa_sig_pkg::cyc_kind_t kind = isa_sig_pkg::KIND_MEM_WRITE;
	logic [23:0] addr = '0;
	logic busy, done, wr_o, wr_oe, wr_i, rd_o, rd_oe, ref_o, ref_oe, ref_i;
	logic [19:0] sa_o, sa_i, ext_sa, m_sa = '0;
	logic sa_oe, la_oe, brst, ext_wr, ext_ref, m_en = 0, m_wr = 1, m_ref = 1;
	logic [6:0] la_o;
	int latch_cnt, lc0, n_fail = 0, tests_run = 0, n_wr, n_rd, n_ref, n_done;
	int n_busy;

	isa_bus_pins #(.HARD_RESET_CYCLES(HR)) DUT (.clk(clk), .rst(rst),
		.power_good_in(pg), .hard_reset_req(hr_req), .own_bus(own),
		.suspend(susp), .cyc_start(start), .cyc_kind(kind),
		.cyc_addr(addr), .cyc_busy(busy), .cyc_done(done),
		.mem_write_strobe_n_out(wr_o), .mem_write_strobe_n_oe_n(wr_oe),
		.mem_write_strobe_n_in(wr_i), .mem_read_strobe_n_out(rd_o),
		.mem_read_strobe_n_oe_n(rd_oe), .refresh_n_out(ref_o),
		.refresh_n_oe_n(ref_oe), .refresh_n_in(ref_i),
		.sys_addr_out(sa_o), .sys_addr_oe_n(sa_oe), .sys_addr_in(sa_i),
		.upper_latched_addr_out(la_o), .upper_latched_addr_oe_n(la_oe),
		.bus_reset_out(brst), .ext_sys_addr(ext_sa),
		.ext_mem_write(ext_wr), .ext_refresh_start(ext_ref));

	isa_far_side far (.clk(clk), .wr_o(wr_o), .wr_oe(wr_oe),
		.ref_o(ref_o), .ref_oe(ref_oe), .sa_o(sa_o), .sa_oe(sa_oe),
		.m_en(m_en), .m_wr(m_wr), .m_ref(m_ref), .m_sa(m_sa),
		.wr_i(wr_i), .ref_i(ref_i), .sa_i(sa_i), .latch_cnt(latch_cnt));

	initial begin
		forever #2 clk = ~clk;
	end

	// wide enough for the latched and system address side by side
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run;
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one request, then eight settled samples of the strobes
	task automatic cyc(input isa_sig_pkg::cyc_kind_t k, input logic [23:0] a);
		@(negedge clk);
		start = 1;
		kind = k;
		addr = a;
		lc0 = latch_cnt;
		@(negedge clk);
		start = 0;
		{n_wr, n_rd, n_ref, n_done, n_busy} = '0;
		// first sample follows the accepting edge, so refresh is counted whole
		repeat (8) begin
			n_wr += !wr_o;
			n_rd += !rd_o;
			n_ref += !ref_o;
			n_done += done;
			n_busy += busy;
			@(negedge clk);
		end
	endtask

	task automatic t_reset;
		repeat (2) @(negedge clk);
		chk({wr_oe, ref_oe, sa_oe, la_oe, brst}, 24'h1F);
		repeat (6) @(negedge clk);
		rst = 0;
		repeat (5) @(negedge clk);
		chk({brst, wr_o, ref_o, wr_oe, sa_oe}, 24'h1C);
		pg = 1;
		repeat (5) @(negedge clk);
		chk(brst, 24'h0);
	endtask

	task automatic t_mem;
		cyc(isa_sig_pkg::KIND_MEM_WRITE, 24'hABCDEF);
		chk({n_wr[3:0], n_rd[3:0], n_done[3:0]}, 24'h301);
		chk(latch_cnt - lc0, 24'h3);
		chk(n_busy[3:0], 24'h5);
		chk({la_o, sa_o}, {7'h55, 20'hBCDEF});
		chk(sa_o[19:17], la_o[2:0]);
		cyc(isa_sig_pkg::KIND_MEM_READ, 24'h0F0001);
		chk({n_wr[3:0], n_rd[3:0], n_done[3:0]}, 24'h031);
		chk({la_o, sa_o}, {7'h07, 20'hF0001});
		cyc(isa_sig_pkg::KIND_IO, 24'h123456);
		chk({n_wr[3:0], n_rd[3:0], n_done[3:0], sa_o[15:0]}, 24'h13456);
		cyc(isa_sig_pkg::KIND_REFRESH, 24'h07FFF0);
		chk({n_ref[3:0], n_rd[3:0], n_wr[3:0], n_done[3:0]}, 24'h5301);
	endtask

	task automatic t_suspend;
		@(negedge clk);
		susp = 1;
		cyc(isa_sig_pkg::KIND_MEM_WRITE, 24'hFFFFFF);
		chk({n_wr[3:0], n_done[3:0], sa_o}, 24'h7FFF0);
		susp = 0;
	endtask

	task automatic t_owner;
		@(negedge clk);
		own = 0;
		cyc(isa_sig_pkg::KIND_MEM_WRITE, 24'h001234);
		chk({n_wr[3:0], n_done[3:0], wr_oe, ref_oe, rd_oe, sa_oe, la_oe},
			24'h1F);
		m_en = 1;
		m_wr = 0;
		m_sa = 20'h5A5A5;
		repeat (5) @(negedge clk);
		chk({ext_wr, ext_sa}, 24'h15A5A5);
		m_ref = 0;
		n_ref = 0;
		repeat (6) begin
			@(negedge clk);
			n_ref += ext_ref;
		end
		chk(n_ref[23:0], 24'h1);
		m_en = 0;
		m_wr = 1;
		m_ref = 1;
		own = 1;
		repeat (2) @(negedge clk);
		chk({wr_oe, sa_oe}, 24'h0);
	endtask

	task automatic t_hard;
		@(negedge clk);
		hr_req = 1;
		@(negedge clk);
		hr_req = 0;
		n_ref = 0;
		// bus reset already rose on the edge that took the request
		repeat (HR + 5) begin
			n_ref += brst;
			@(negedge clk);
		end
		chk(n_ref[23:0], HR);
	endtask

	initial begin
		t_reset;
		t_mem;
		t_suspend;
		t_owner;
		t_hard;
		complete_run;
	end

	// the whole run needs about 120 cycles
	initial begin
		#20000;
		n_fail++;
		complete_run;
	end
endmodule // tb_isa_bus_pins
